// *** ddc_dual_dac_command_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddc_dual_dac_command_decoder (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          three_wire_mode_i,
  input  wire logic [1:0]    slave_addr_i,
  input  wire logic          ser_clk_i,
  input  wire logic          ser_data_i,
  input  wire logic          chip_select_n_i,
  output var  logic          ser_data_o,
  output var  logic          ser_data_oe_o,
  output var  ddc_pkg::ddc_chan_s channel_a_converter_o,
  output var  ddc_pkg::ddc_chan_s channel_b_converter_o,
  output var  logic          ref_internal_o
);
  import ddc_pkg::*;

  logic [SYNC_W-1:0] s1, s2, s3, filt, filt_q;
  logic [SYNC_W-1:0] next_s1, next_s2, next_s3, next_filt;
  logic              clk_rise, clk_fall, data_rise, data_fall, cs_rise, cs_fall;
  logic              mode3, start_cond, stop_cond;

  // a level counts only once the last two stages agree
  always_comb begin
    next_s1   = {slave_addr_i, three_wire_mode_i, chip_select_n_i, ser_data_i, ser_clk_i};
    next_s2   = s1;
    next_s3   = s2;
    next_filt = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s1     <= SYNC_RST;
      s2     <= SYNC_RST;
      s3     <= SYNC_RST;
      filt   <= SYNC_RST;
      filt_q <= SYNC_RST;
    end else begin
      s1     <= next_s1;
      s2     <= next_s2;
      s3     <= next_s3;
      filt   <= next_filt;
      filt_q <= filt;
    end
  end

  assign clk_rise   = filt[0] & ~filt_q[0];
  assign clk_fall   = ~filt[0] & filt_q[0];
  assign data_rise  = filt[1] & ~filt_q[1];
  assign data_fall  = ~filt[1] & filt_q[1];
  assign cs_rise    = filt[2] & ~filt_q[2];
  assign cs_fall    = ~filt[2] & filt_q[2];
  assign mode3      = filt[3];
  assign start_cond = filt[0] & filt_q[0] & data_fall;
  assign stop_cond  = filt[0] & filt_q[0] & data_rise;

  // three-wire receiver
  logic [FRAME_W-1:0] sh3, next_sh3;
  logic [CNT_W-1:0]   cnt3, next_cnt3;
  logic               go3;

  always_comb begin
    next_sh3  = sh3;
    next_cnt3 = cnt3;
    go3       = mode3 & cs_rise & (cnt3 == TW3_BITS); // R18 R17
    if (mode3 && cs_fall) begin
      next_cnt3 = '0;
    end else if (mode3 && !filt[2] && clk_rise) begin
      next_sh3 = {sh3[FRAME_W-2:0], filt[1]};
      // only a full frame executes; extra bits saturate the count
      if (cnt3 != TW3_BITS) begin
        next_cnt3 = CNT_W'(cnt3 + 5'h01);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sh3  <= '0;
      cnt3 <= '0;
    end else begin
      sh3  <= next_sh3;
      cnt3 <= next_cnt3;
    end
  end

  // two-wire receiver
  ddc_tw_state_e      tw_state, next_tw_state;
  logic [CNT_W-1:0]   tw_cnt, next_tw_cnt, tw_cnt_inc;
  logic [TW_SH_W-1:0] tw_sh, next_tw_sh, tw_word;
  logic               ack_oe, next_ack_oe, go2;
  logic [FRAME_W-1:0] tw_frame;

  assign tw_cnt_inc = CNT_W'(tw_cnt + 5'h01);
  assign tw_word    = {tw_sh[TW_SH_W-2:0], filt[1]};
  // drop the acknowledge slot between the two body bytes
  assign tw_frame   = {tw_word[16:9], tw_word[7:0]};

  always_comb begin
    next_tw_state = tw_state;
    next_tw_cnt   = tw_cnt;
    next_tw_sh    = tw_sh;
    next_ack_oe   = ack_oe;
    go2           = 1'b0;
    if (mode3) begin
      next_tw_state = TW_IDLE;
      next_ack_oe   = 1'b0;
    end else if (start_cond) begin
      next_tw_state = TW_ACTIVE;
      next_tw_cnt   = '0;
      next_ack_oe   = 1'b0;
    end else if (stop_cond) begin
      // early stop aborts without touching any register
      next_tw_state = TW_IDLE; // R19
      next_ack_oe   = 1'b0;
    end else begin
      case (tw_state)
        TW_ACTIVE: begin
          if (clk_rise) begin
            next_tw_cnt = tw_cnt_inc;
            next_tw_sh  = tw_word;
            if (tw_cnt_inc == TW_ADDR_EDGE &&
                tw_word[7:0] != {TW_ADDR_PREFIX, filt[5:4], 1'b0}) begin
              next_tw_state = TW_SKIP;
            end
            if (tw_cnt_inc == TW_EXEC_EDGE) begin
              go2 = 1'b1; // R19 R17
            end
            if (tw_cnt_inc == TW_LAST_EDGE) begin
              next_tw_state = TW_SKIP;
            end
          end else if (clk_fall) begin
            next_ack_oe = (tw_cnt == TW_ADDR_EDGE) || (tw_cnt == TW_ACK2_EDGE) ||
                          (tw_cnt == TW_EXEC_EDGE);
          end
        end
        TW_SKIP: begin
          if (clk_fall) begin
            next_ack_oe = 1'b0;
          end
        end
        TW_IDLE: begin
          next_ack_oe = 1'b0;
        end
        default: begin
          next_tw_state = TW_IDLE;
          next_ack_oe   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tw_state      <= TW_IDLE;
      tw_cnt        <= '0;
      tw_sh         <= '0;
      ack_oe        <= 1'b0;
      ser_data_oe_o <= 1'b0;
      ser_data_o    <= 1'b0;
    end else begin
      tw_state      <= next_tw_state;
      tw_cnt        <= next_tw_cnt;
      tw_sh         <= next_tw_sh;
      ack_oe        <= next_ack_oe;
      ser_data_oe_o <= next_ack_oe;
      ser_data_o    <= 1'b0;
    end
  end

  // command execution
  logic       exec, next_exec;
  ddc_frame_s frame, next_frame;
  ddc_chan_s  ch_a, ch_b, next_ch_a, next_ch_b;
  logic       ref_int, next_ref_int;

  always_comb begin
    next_exec  = go2 | go3;
    next_frame = go2 ? ddc_frame_s'(tw_frame) : ddc_frame_s'(sh3);
    if (!next_exec) begin
      next_frame = frame;
    end
  end

  // decoding ignores enable, so loads work while shut down
  always_comb begin
    next_ch_a    = ch_a;
    next_ch_b    = ch_b;
    next_ref_int = ref_int;
    if (exec) begin // R20
      if (frame.cmd[5:3] == RANGE_GRP_A && frame.cmd[2:0] <= RANGE_MAX) begin
        next_ch_a.range = frame.cmd[2:0]; // R13
      end
      if (frame.cmd[5:3] == RANGE_GRP_B && frame.cmd[2:0] <= RANGE_MAX) begin
        next_ch_b.range = frame.cmd[2:0]; // R14
      end
      case (frame.cmd)
        CMD_LOAD_BOTH: begin // R1
          next_ch_a.input_code  = frame.payload;
          next_ch_a.active_code = frame.payload;
          next_ch_b.input_code  = frame.payload;
          next_ch_b.active_code = frame.payload;
        end
        CMD_LOAD_A: begin // R2
          next_ch_a.input_code  = frame.payload;
          next_ch_a.active_code = frame.payload;
        end
        CMD_LOAD_B: begin // R3
          next_ch_b.input_code  = frame.payload;
          next_ch_b.active_code = frame.payload;
        end
        CMD_IN_BOTH: begin // R4
          next_ch_a.input_code = frame.payload;
          next_ch_b.input_code = frame.payload;
        end
        CMD_IN_A: next_ch_a.input_code = frame.payload; // R5
        CMD_IN_B: next_ch_b.input_code = frame.payload; // R6
        CMD_UPD_BOTH: begin // R7
          next_ch_a.active_code = ch_a.input_code;
          next_ch_b.active_code = ch_b.input_code;
        end
        CMD_UPD_A:   next_ch_a.active_code = ch_a.input_code; // R8
        CMD_UPD_B:   next_ch_b.active_code = ch_b.input_code; // R9
        CMD_REF_INT: next_ref_int = 1'b1; // R10
        CMD_REF_EXT: next_ref_int = 1'b0; // R10
        // shutdown touches only the enable bit
        CMD_SHDN_BOTH: begin // R11 R16
          next_ch_a.enabled = 1'b0;
          next_ch_b.enabled = 1'b0;
        end
        CMD_SHDN_A: next_ch_a.enabled = 1'b0; // R11 R16
        CMD_SHDN_B: next_ch_b.enabled = 1'b0; // R11 R16
        CMD_PWR_BOTH: begin // R12
          next_ch_a.enabled = 1'b1;
          next_ch_b.enabled = 1'b1;
        end
        CMD_PWR_A: next_ch_a.enabled = 1'b1; // R12
        CMD_PWR_B: next_ch_b.enabled = 1'b1; // R12
        default: begin
          // nop and unlisted codes fall here unchanged
          next_ref_int = ref_int; // R15
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      exec                  <= 1'b0;
      frame                 <= '0;
      ch_a                  <= '{RST_CODE, RST_CODE, RST_RANGE, RST_ENABLE};
      ch_b                  <= '{RST_CODE, RST_CODE, RST_RANGE, RST_ENABLE};
      ref_int               <= RST_REF_INT;
      channel_a_converter_o <= '{RST_CODE, RST_CODE, RST_RANGE, RST_ENABLE};
      channel_b_converter_o <= '{RST_CODE, RST_CODE, RST_RANGE, RST_ENABLE};
      ref_internal_o        <= RST_REF_INT;
    end else begin
      exec                  <= next_exec;
      frame                 <= next_frame;
      ch_a                  <= next_ch_a;
      ch_b                  <= next_ch_b;
      ref_int               <= next_ref_int;
      channel_a_converter_o <= next_ch_a;
      channel_b_converter_o <= next_ch_b;
      ref_internal_o        <= next_ref_int;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  load_both_a: assert property (exec && frame.cmd == CMD_LOAD_BOTH |=> // R1
    ch_a.active_code == $past(frame.payload) && ch_b.input_code == $past(frame.payload))
    else $error("load both mismatch");
  load_a_only_a: assert property (exec && frame.cmd == CMD_LOAD_A |=> // R2
    ch_a.active_code == $past(frame.payload) && $stable(ch_b))
    else $error("load a disturbed b");
  load_b_only_a: assert property (exec && frame.cmd == CMD_LOAD_B |=> // R3
    ch_b.input_code == $past(frame.payload) && $stable(ch_a))
    else $error("load b disturbed a");
  input_hold_a: assert property (exec && frame.cmd == CMD_IN_BOTH |=> // R4
    $stable(ch_a.active_code) && ch_a.input_code == $past(frame.payload))
    else $error("input load moved active");
  xfer_both_a: assert property (exec && frame.cmd == CMD_UPD_BOTH |=> // R7
    ch_a.active_code == $past(ch_a.input_code) && ch_b.active_code == $past(ch_b.input_code))
    else $error("transfer failed");
  ref_sel_a: assert property (exec && frame.cmd == CMD_REF_INT |=> ref_internal_o && ref_int) // R10
    else $error("reference select lost");
  ref_ext_a: assert property (exec && frame.cmd == CMD_REF_EXT |=> !ref_internal_o && !ref_int) // R10
    else $error("external reference not taken");
  shdn_keep_a: assert property (exec && frame.cmd == CMD_SHDN_A |=> // R11 R16
    !channel_a_converter_o.enabled && channel_a_converter_o.active_code == $past(ch_a.active_code))
    else $error("shutdown lost state");
  pwr_up_a: assert property (exec && frame.cmd == CMD_PWR_BOTH |=> ch_a.enabled && ch_b.enabled) // R12
    else $error("power up failed");
  range_b_a: assert property (exec && frame.cmd[5:3] == RANGE_GRP_B && frame.cmd[2:0] <= RANGE_MAX // R14
    |=> ch_b.range == $past(frame.cmd[2:0]) && $stable(ch_a.range))
    else $error("range b wrong");
  nop_hold_a: assert property (exec && frame.cmd == CMD_NOP |=> // R15
    $stable(ch_a) && $stable(ch_b) && $stable(ref_int))
    else $error("nop changed state");
  tw_exec_a: assert property (go2 |-> tw_cnt_inc == TW_EXEC_EDGE ##1 exec) // R19
    else $error("two-wire exec at wrong edge");
  three_exec_a: assert property (go3 |-> cnt3 == TW3_BITS && mode3 ##1 exec) // R18
    else $error("three-wire exec without full frame");
endmodule
`default_nettype wire

// *** ddc_pkg.sv ***
// Functional notes
// R1 - 000001 loads payload into all four registers
// R2 - 000010 loads channel a input and active
// R3 - 000011 loads channel b input and active
// R4 - 000100 loads both input registers only
// R5 - 000101 loads channel a input register only
// R6 - 000110 loads channel b input register only
// R7 - 000111 copies both inputs to active together
// R8 - 001001 copies channel a input to active
// R9 - 001010 copies channel b input to active
// R10 - 001011 internal, 001100 external reference, external default
// R11 - 001101/001110/001111 shut down both, a, b
// R12 - 101101/101110/101111 power up both, a, b
// R13 - 010000-010101 pick channel a range, lowest default
// R14 - 110000-110101 pick channel b range, lowest default
// R15 - nop and unlisted codes change nothing
// R16 - shutdown only gates enable, settings kept
// R17 - frame: six command, eight payload, two zero
// R18 - three-wire: execute when chip select rises
// R19 - two-wire: execute on 26th clock rise
// R20 - commands still execute while channels shut down
`default_nettype none
package ddc_pkg;
  localparam int CMD_W   = 6;
  localparam int PAY_W   = 8;
  localparam int SUB_W   = 2;
  localparam int FRAME_W = 16;
  localparam int RANGE_W = 3;
  localparam int CNT_W   = 5;
  localparam int SYNC_W  = 6;
  localparam int TW_SH_W = 26;

  localparam logic [CMD_W-1:0] CMD_NOP       = 6'h00;
  localparam logic [CMD_W-1:0] CMD_LOAD_BOTH = 6'h01;
  localparam logic [CMD_W-1:0] CMD_LOAD_A    = 6'h02;
  localparam logic [CMD_W-1:0] CMD_LOAD_B    = 6'h03;
  localparam logic [CMD_W-1:0] CMD_IN_BOTH   = 6'h04;
  localparam logic [CMD_W-1:0] CMD_IN_A      = 6'h05;
  localparam logic [CMD_W-1:0] CMD_IN_B      = 6'h06;
  localparam logic [CMD_W-1:0] CMD_UPD_BOTH  = 6'h07;
  localparam logic [CMD_W-1:0] CMD_UPD_A     = 6'h09;
  localparam logic [CMD_W-1:0] CMD_UPD_B     = 6'h0a;
  localparam logic [CMD_W-1:0] CMD_REF_INT   = 6'h0b;
  localparam logic [CMD_W-1:0] CMD_REF_EXT   = 6'h0c;
  localparam logic [CMD_W-1:0] CMD_SHDN_BOTH = 6'h0d;
  localparam logic [CMD_W-1:0] CMD_SHDN_A    = 6'h0e;
  localparam logic [CMD_W-1:0] CMD_SHDN_B    = 6'h0f;
  localparam logic [CMD_W-1:0] CMD_PWR_BOTH  = 6'h2d;
  localparam logic [CMD_W-1:0] CMD_PWR_A     = 6'h2e;
  localparam logic [CMD_W-1:0] CMD_PWR_B     = 6'h2f;
  // range commands: group in cmd[5:3], range index in cmd[2:0]
  localparam logic [2:0]         RANGE_GRP_A = 3'h2;
  localparam logic [2:0]         RANGE_GRP_B = 3'h6;
  localparam logic [RANGE_W-1:0] RANGE_MAX   = 3'h5;

  localparam logic [PAY_W-1:0]   RST_CODE    = 8'h00;
  localparam logic [RANGE_W-1:0] RST_RANGE   = 3'h0;
  localparam logic               RST_REF_INT = 1'b0;
  localparam logic               RST_ENABLE  = 1'b1;
  // pin order: 0 clock, 1 data, 2 chip select, 3 mode, 5:4 address
  localparam logic [SYNC_W-1:0]  SYNC_RST    = 6'h07;

  localparam logic [4:0]       TW_ADDR_PREFIX = 5'h0c;
  localparam logic [CNT_W-1:0] TW_ADDR_EDGE   = 5'h08;
  localparam logic [CNT_W-1:0] TW_ACK2_EDGE   = 5'h11;
  localparam logic [CNT_W-1:0] TW_EXEC_EDGE   = 5'h1a;
  localparam logic [CNT_W-1:0] TW_LAST_EDGE   = 5'h1b;
  localparam logic [CNT_W-1:0] TW3_BITS       = 5'h10;

  typedef enum logic [1:0] {TW_IDLE, TW_ACTIVE, TW_SKIP} ddc_tw_state_e;

  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic [PAY_W-1:0] payload;
    logic [SUB_W-1:0] sub;
  } ddc_frame_s;

  typedef struct packed {
    logic [PAY_W-1:0]   input_code;
    logic [PAY_W-1:0]   active_code;
    logic [RANGE_W-1:0] range;
    logic               enabled;
  } ddc_chan_s;
endpackage
`default_nettype wire

// *** ddc_dual_dac_command_decoder_end.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** ddc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddc_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o,
  output var  logic cs_n_o
);
  int acks;

  initial begin
    scl_o  = 1'b1;
    sda_o  = 1'b1;
    cs_n_o = 1'b1;
    acks   = 0;
  end

  // six clocks per phase, above the filter minimum of two
  task automatic ph();
    repeat (6) @(negedge clk_i);
  endtask

  // nbits below 16 models a frame cut short
  task automatic send3(input logic [15:0] f, input int nbits);
    cs_n_o = 1'b0;
    ph();
    for (int i = 0; i < nbits; i++) begin
      scl_o = 1'b0;
      sda_o = f[15-i];
      ph();
      scl_o = 1'b1;
      ph();
    end
    cs_n_o = 1'b1;
    sda_o  = ~sda_o;
    ph();
  endtask

  // ack slots are released high; the stop adds one more rise,
  // so nrises below 25 aborts before the executing rise
  task automatic send2(input logic [7:0] adr, input logic [15:0] f, input int nrises);
    logic [26:0] bits;
    bits  = {adr, 1'b1, f[15:8], 1'b1, f[7:0], 1'b1};
    acks  = 0;
    sda_o = 1'b1;
    ph();
    sda_o = 1'b0;
    ph();
    for (int i = 0; i < nrises; i++) begin
      scl_o = 1'b0;
      sda_o = bits[26-i];
      ph();
      scl_o = 1'b1;
      ph();
      if (i % 9 == 8 && sda_i === 1'b0) acks++;
    end
    scl_o = 1'b0;
    sda_o = 1'b0;
    ph();
    scl_o = 1'b1;
    ph();
    sda_o = 1'b1;
    ph();
  endtask
endmodule
`default_nettype wire

// *** ddc_dual_dac_command_decoder_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddc_dual_dac_command_decoder_bench;
  import ddc_pkg::*;
  logic       clk_i    = 1'b0;
  logic       resetn_i = 1'b0;
  logic       mode     = 1'b1;
  logic [1:0] addr     = 2'h2;
  logic       scl;
  logic       sda_h;
  logic       cs_n;
  logic       sda_o;
  logic       sda_oe;
  logic       ref_int;
  logic       sda_w;
  ddc_chan_s  cha;
  ddc_chan_s  chb;
  ddc_chan_s  ea;
  ddc_chan_s  eb;
  logic       eref;
  int         mismatches = 0;
  int         num_checks = 0;
  int         cycles     = 0;
  logic [13:0] seq [26] = '{14'h01a5, 14'h023c, 14'h03c3, 14'h0411, 14'h0522, 14'h0633, 14'h07ff,
                            14'h0544, 14'h0900, 14'h0655, 14'h0a00, 14'h0b00, 14'h0c00, 14'h0b00,
                            14'h0d00, 14'h0177, 14'h2e00, 14'h2f00, 14'h0e00, 14'h0f00, 14'h2d00,
                            14'h00ff, 14'h08ff, 14'h1600, 14'h3e00, 14'h3fff};

  always #4 clk_i = ~clk_i;
  // pull-up on the data wire, device only pulls low
  assign sda_w = sda_oe ? 1'b0 : sda_h;

  ddc_dual_dac_command_decoder u_dut (
    .clk_i                 (clk_i),
    .resetn_i              (resetn_i),
    .three_wire_mode_i     (mode),
    .slave_addr_i          (addr),
    .ser_clk_i             (scl),
    .ser_data_i            (sda_w),
    .chip_select_n_i       (cs_n),
    .ser_data_o            (sda_o),
    .ser_data_oe_o         (sda_oe),
    .channel_a_converter_o (cha),
    .channel_b_converter_o (chb),
    .ref_internal_o        (ref_int)
  );

  ddc_host_model u_host (
    .clk_i  (clk_i),
    .sda_i  (sda_w),
    .scl_o  (scl),
    .sda_o  (sda_h),
    .cs_n_o (cs_n)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic cmp(input logic [40:0] got, input logic [40:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk();
    cmp({cha, chb, ref_int}, {ea, eb, eref});
  endtask

  // expected state worked out from the command table, codes written out literally
  task automatic expect_cmd(input logic [13:0] cp);
    logic [5:0] c;
    logic [7:0] p;
    c = cp[13:8];
    p = cp[7:0];
    if (c inside {6'h01, 6'h02, 6'h04, 6'h05}) ea.input_code = p;
    if (c inside {6'h01, 6'h03, 6'h04, 6'h06}) eb.input_code = p;
    if (c inside {6'h01, 6'h02}) ea.active_code = p;
    if (c inside {6'h01, 6'h03}) eb.active_code = p;
    if (c inside {6'h07, 6'h09}) ea.active_code = ea.input_code;
    if (c inside {6'h07, 6'h0a}) eb.active_code = eb.input_code;
    if (c == 6'h0b) eref = 1'b1;
    if (c == 6'h0c) eref = 1'b0;
    if (c inside {6'h0d, 6'h0e}) ea.enabled = 1'b0;
    if (c inside {6'h0d, 6'h0f}) eb.enabled = 1'b0;
    if (c inside {6'h2d, 6'h2e}) ea.enabled = 1'b1;
    if (c inside {6'h2d, 6'h2f}) eb.enabled = 1'b1;
    if (c[5:3] == 3'h2 && c[2:0] <= 3'h5) ea.range = c[2:0];
    if (c[5:3] == 3'h6 && c[2:0] <= 3'h5) eb.range = c[2:0];
  endtask

  // outputs settle about six clocks after chip select rises, margin added
  task automatic run3(input logic [13:0] cp);
    u_host.send3({cp, 2'b00}, 16);
    repeat (4) @(negedge clk_i);
    expect_cmd(cp);
    chk();
  endtask

  initial begin
    ea   = '{8'h00, 8'h00, 3'h0, 1'b1};
    eb   = '{8'h00, 8'h00, 3'h0, 1'b1};
    eref = 1'b0;
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (10) @(negedge clk_i);
    chk();
    foreach (seq[i]) run3(seq[i]);
    for (int r = 5; r >= 0; r--) begin
      run3({3'h2, r[2:0], 8'h00});
      run3({3'h6, r[2:0], 8'h00});
    end
    u_host.send3({14'h0199, 2'b00}, 15);
    repeat (4) @(negedge clk_i);
    chk();
    // two-wire mode: address byte 0110_0 a1 a0 w
    mode = 1'b0;
    repeat (10) @(negedge clk_i);
    u_host.send2(8'h64, {14'h025a, 2'b00}, 27);
    expect_cmd(14'h025a);
    chk();
    cmp(u_host.acks, 3);
    cmp({40'h0, sda_o}, 41'h0);
    u_host.send2(8'h64, {14'h010f, 2'b00}, 24);
    chk();
    cmp(u_host.acks, 2);
    u_host.send2(8'h66, {14'h010f, 2'b00}, 27);
    chk();
    cmp(u_host.acks, 0);
    u_host.send2(8'h65, {14'h010f, 2'b00}, 27);
    chk();
    cmp(u_host.acks, 0);
    conclude();
  end
endmodule
`default_nettype wire
